// file: bbs_pkg.sv
// Constants shared by the branch and bit-set execution unit
package bbs_pkg;
   // Widths
   localparam int PC_W          = 21;
   localparam int INSTR_W       = 16;
   localparam int BSR_W         = 6;
   localparam int ADDR_W        = 14;
   localparam int NEAR_OFS_W    = 8;
   localparam int FAR_OFS_W     = 11;
   // Opcode fields
   localparam int OP_NEAR_MSB   = 15;
   localparam int OP_NEAR_LSB   = 8;
   localparam int OP_FAR_MSB    = 15;
   localparam int OP_FAR_LSB    = 11;
   localparam int OP_BIT_MSB    = 15;
   localparam int OP_BIT_LSB    = 12;
   localparam logic [7:0] OPC_BRANCH_IF_ZERO_CLEAR = 8'he1;
   localparam logic [4:0] OPC_RELATIVE_JUMP        = 5'h1a;
   localparam logic [3:0] OPC_SINGLE_BIT_SET       = 4'h8;
   // Bit-oriented operand fields
   localparam int BIT_IDX_MSB   = 11;
   localparam int BIT_IDX_LSB   = 9;
   localparam int ACCESS_BIT    = 8;
   localparam int REG_F_MSB     = 7;
   localparam int REG_F_LSB     = 0;
   // Access bank split and indexed literal offset limit
   localparam logic [7:0] ACCESS_LOW_LAST = 8'h5f;
   // Reset values
   localparam logic [PC_W-1:0]    PC_RST    = 21'h000000;
   localparam logic [INSTR_W-1:0] INSTR_RST = 16'h0000;
   localparam logic [7:0]         DATA_RST  = 8'h00;
   // Instruction cycle phases, Gray coded along Q1..Q4
   typedef enum logic [1:0]
   {
      PH_Q1 = 2'b00,
      PH_Q2 = 2'b01,
      PH_Q3 = 2'b11,
      PH_Q4 = 2'b10
   } bbs_phase_e;
   // Execution slot: normal decode or forced no-operation cycle
   typedef enum logic [0:0]
   {
      EX_RUN = 1'b0,
      EX_NOP = 1'b1
   } bbs_exec_e;
   // Phases per instruction cycle
   localparam int CYCLE_PHASES = 4;
endpackage

// file: bbs_operand_addr.sv
// Operand address generator for bit-oriented data memory access
`timescale 1ns/10ps
module bbs_operand_addr #(
   parameter int BSR_W  = bbs_pkg::BSR_W,
   parameter int ADDR_W = bbs_pkg::ADDR_W
) (
   input  wire logic              clk_sys_i,
   input  wire logic              sys_rst_i,
   input  wire logic              clk_en_i,
   input  wire logic              load_i,
   input  wire logic              access_bit_i,
   input  wire logic [7:0]        reg_f_i,
   input  wire logic [BSR_W-1:0]  bank_selector_reg_i,
   input  wire logic              ext_set_en_i,
   input  wire logic [ADDR_W-1:0] index_base_i,
   output logic      [ADDR_W-1:0] addr_o
);
   logic [ADDR_W-1:0] addr_reg;
   logic [ADDR_W-1:0] addr_next;
   logic              low_part;

   always_comb
   begin
      low_part  = (reg_f_i <= bbs_pkg::ACCESS_LOW_LAST);
      addr_next = addr_reg;
      if (load_i)
      begin
         if (access_bit_i)
            addr_next = ADDR_W'({bank_selector_reg_i, reg_f_i});
         else if (ext_set_en_i && low_part)
            addr_next = ADDR_W'(index_base_i + ADDR_W'(reg_f_i));
         else if (low_part)
            addr_next = ADDR_W'(reg_f_i);
         else
            addr_next = {{(ADDR_W-8){1'b1}}, reg_f_i};
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
         addr_reg <= '0;
      else if (clk_en_i)
         addr_reg <= addr_next;
   end

   assign addr_o = addr_reg;
endmodule

// file: bbs_exec.sv
// Execution of the not-zero branch, the relative jump and the single bit set
// Overview of operation
// - Not-zero branch loads target only when zero flag is clear; flags untouched.
// - Target is incremented PC plus twice signed offset; near offset is 8 bits.
// - Not-zero branch: one word, one cycle untaken, two cycles taken.
// - Relative jump carries 11-bit signed offset and always transfers control.
// - Relative jump always takes two cycles, the second being no operation.
// - Bit set forces chosen bit of addressed register high in one cycle.
// - Access bit zero selects access bank; one uses the bank selector.
// - Extended set, access bit zero and f up to 95 uses indexed offset.
`timescale 1ns/10ps
module bbs_exec #(
   parameter int PC_W   = bbs_pkg::PC_W,
   parameter int BSR_W  = bbs_pkg::BSR_W,
   parameter int ADDR_W = bbs_pkg::ADDR_W
) (
   input  wire logic                        clk_sys_i,
   input  wire logic                        sys_rst_i,
   input  wire logic                        clk_en_i,
   input  wire logic                        instr_valid_i,
   input  wire logic [bbs_pkg::INSTR_W-1:0] instr_word_i,
   input  wire logic [PC_W-1:0]             pc_i,
   input  wire logic                        zero_flag_i,
   input  wire logic [BSR_W-1:0]            bank_selector_reg_i,
   input  wire logic                        ext_set_en_i,
   input  wire logic [ADDR_W-1:0]           index_base_i,
   input  wire logic [7:0]                  mem_rdata_i,
   output logic                             instr_ready_o,
   output logic [1:0]                       phase_o,
   output logic                             pc_load_o,
   output logic [PC_W-1:0]                  pc_target_o,
   output logic                             flush_o,
   output logic                             nop_cycle_o,
   output logic [ADDR_W-1:0]                mem_addr_o,
   output logic                             mem_rd_o,
   output logic                             mem_wr_o,
   output logic [7:0]                       mem_wdata_o
);
   // Sign-extend an offset field, double it and add it to the base
   function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] base,
                                                  input logic [10:0]     ofs,
                                                  input logic            far);
      logic [PC_W-1:0] ext;
      ext = '0;
      if (far)
         ext = PC_W'(signed'(ofs));
      else
         ext = PC_W'(signed'(ofs[7:0]));
      return PC_W'(base + PC_W'(ext << 1));
   endfunction

   bbs_pkg::bbs_phase_e             phase_reg;
   bbs_pkg::bbs_phase_e             phase_next;
   bbs_pkg::bbs_exec_e              exec_reg;
   bbs_pkg::bbs_exec_e              exec_next;
   logic [bbs_pkg::INSTR_W-1:0]     ir_reg;
   logic [bbs_pkg::INSTR_W-1:0]     ir_next;
   logic [PC_W-1:0]                 pc_base_reg;
   logic [PC_W-1:0]                 pc_base_next;
   logic                            is_bnz_reg;
   logic                            is_bnz_next;
   logic                            is_jump_reg;
   logic                            is_jump_next;
   logic                            is_bset_reg;
   logic                            is_bset_next;
   logic                            taken_reg;
   logic                            taken_next;
   logic [PC_W-1:0]                 target_reg;
   logic [PC_W-1:0]                 target_next;
   logic                            pc_load_reg;
   logic                            pc_load_next;
   logic                            mem_rd_reg;
   logic                            mem_rd_next;
   logic                            mem_wr_reg;
   logic                            mem_wr_next;
   logic [7:0]                      wdata_reg;
   logic [7:0]                      wdata_next;
   logic                            accept;
   logic                            dec_bnz;
   logic                            dec_jump;
   logic                            dec_bset;
   logic [2:0]                      bit_idx;

   // Decode of the word presented in Q1
   assign dec_bnz  = instr_word_i[bbs_pkg::OP_NEAR_MSB:bbs_pkg::OP_NEAR_LSB]
                     == bbs_pkg::OPC_BRANCH_IF_ZERO_CLEAR;
   assign dec_jump = instr_word_i[bbs_pkg::OP_FAR_MSB:bbs_pkg::OP_FAR_LSB]
                     == bbs_pkg::OPC_RELATIVE_JUMP;
   assign dec_bset = instr_word_i[bbs_pkg::OP_BIT_MSB:bbs_pkg::OP_BIT_LSB]
                     == bbs_pkg::OPC_SINGLE_BIT_SET;
   // The forced no-operation cycle refuses the prefetched word
   assign accept   = (phase_reg == bbs_pkg::PH_Q1) && (exec_reg == bbs_pkg::EX_RUN)
                     && instr_valid_i;
   assign bit_idx  = ir_reg[bbs_pkg::BIT_IDX_MSB:bbs_pkg::BIT_IDX_LSB];

   always_comb
   begin
      phase_next   = phase_reg;
      exec_next    = exec_reg;
      ir_next      = ir_reg;
      pc_base_next = pc_base_reg;
      is_bnz_next  = is_bnz_reg;
      is_jump_next = is_jump_reg;
      is_bset_next = is_bset_reg;
      taken_next   = taken_reg;
      target_next  = target_reg;
      pc_load_next = 1'b0;
      mem_rd_next  = 1'b0;
      mem_wr_next  = 1'b0;
      wdata_next   = wdata_reg;
      case (phase_reg)
         bbs_pkg::PH_Q1:
         begin
            phase_next = bbs_pkg::PH_Q2;
            if (accept)
            begin
               // Decode and latch the already incremented PC
               ir_next      = instr_word_i;
               pc_base_next = pc_i;
               is_bnz_next  = dec_bnz;
               is_jump_next = dec_jump;
               is_bset_next = dec_bset;
               mem_rd_next  = dec_bset;
            end
            else
            begin
               is_bnz_next  = 1'b0;
               is_jump_next = 1'b0;
               is_bset_next = 1'b0;
            end
         end
         bbs_pkg::PH_Q2:
         begin
            // Read literal; branch condition sampled here
            phase_next = bbs_pkg::PH_Q3;
            taken_next = is_jump_reg || (is_bnz_reg && !zero_flag_i);
         end
         bbs_pkg::PH_Q3:
         begin
            // Process data
            phase_next   = bbs_pkg::PH_Q4;
            target_next  = rel_target(pc_base_reg, ir_reg[10:0], is_jump_reg);
            pc_load_next = taken_reg;
            if (is_bset_reg)
            begin
               wdata_next  = mem_rdata_i | (8'h01 << bit_idx);
               mem_wr_next = 1'b1;
            end
         end
         bbs_pkg::PH_Q4:
         begin
            phase_next = bbs_pkg::PH_Q1;
            // Taken branch: next cycle, all four phases, executes as no operation
            if (taken_reg)
               exec_next = bbs_pkg::EX_NOP;
            else
               exec_next = bbs_pkg::EX_RUN;
            taken_next = 1'b0;
         end
         default:
         begin
            phase_next = bbs_pkg::PH_Q1;
            exec_next  = bbs_pkg::EX_RUN;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         phase_reg   <= bbs_pkg::PH_Q1;
         exec_reg    <= bbs_pkg::EX_RUN;
         ir_reg      <= bbs_pkg::INSTR_RST;
         pc_base_reg <= bbs_pkg::PC_RST;
         is_bnz_reg  <= 1'b0;
         is_jump_reg <= 1'b0;
         is_bset_reg <= 1'b0;
         taken_reg   <= 1'b0;
         target_reg  <= bbs_pkg::PC_RST;
         pc_load_reg <= 1'b0;
         mem_rd_reg  <= 1'b0;
         mem_wr_reg  <= 1'b0;
         wdata_reg   <= bbs_pkg::DATA_RST;
      end
      else if (clk_en_i)
      begin
         phase_reg   <= phase_next;
         exec_reg    <= exec_next;
         ir_reg      <= ir_next;
         pc_base_reg <= pc_base_next;
         is_bnz_reg  <= is_bnz_next;
         is_jump_reg <= is_jump_next;
         is_bset_reg <= is_bset_next;
         taken_reg   <= taken_next;
         target_reg  <= target_next;
         pc_load_reg <= pc_load_next;
         mem_rd_reg  <= mem_rd_next;
         mem_wr_reg  <= mem_wr_next;
         wdata_reg   <= wdata_next;
      end
   end

   bbs_operand_addr #(
      .BSR_W  (BSR_W),
      .ADDR_W (ADDR_W)
   ) u_operand_addr (
      .clk_sys_i           (clk_sys_i),
      .sys_rst_i           (sys_rst_i),
      .clk_en_i            (clk_en_i),
      .load_i              (accept && dec_bset),
      .access_bit_i        (instr_word_i[bbs_pkg::ACCESS_BIT]),
      .reg_f_i             (instr_word_i[bbs_pkg::REG_F_MSB:bbs_pkg::REG_F_LSB]),
      .bank_selector_reg_i (bank_selector_reg_i),
      .ext_set_en_i        (ext_set_en_i),
      .index_base_i        (index_base_i),
      .addr_o              (mem_addr_o)
   );

   assign instr_ready_o = (phase_reg == bbs_pkg::PH_Q1) && (exec_reg == bbs_pkg::EX_RUN);
   assign phase_o       = phase_reg;
   assign pc_load_o     = pc_load_reg;
   assign pc_target_o   = target_reg;
   assign flush_o       = pc_load_reg;
   assign nop_cycle_o   = (exec_reg == bbs_pkg::EX_NOP);
   assign mem_rd_o      = mem_rd_reg;
   assign mem_wr_o      = mem_wr_reg;
   assign mem_wdata_o   = wdata_reg;
endmodule

// file: bbs_exec_checker.sv
// Concurrent checks on the ports of the branch and bit-set execution unit
`timescale 1ns/10ps
module bbs_exec_checker #(
   parameter int PC_W   = 21,
   parameter int BSR_W  = 6,
   parameter int ADDR_W = 14
) (
   input wire logic              clk_sys_i,
   input wire logic              sys_rst_i,
   input wire logic              clk_en_i,
   input wire logic              instr_valid_i,
   input wire logic [15:0]       instr_word_i,
   input wire logic [PC_W-1:0]   pc_i,
   input wire logic              zero_flag_i,
   input wire logic [BSR_W-1:0]  bank_selector_reg_i,
   input wire logic              ext_set_en_i,
   input wire logic [ADDR_W-1:0] index_base_i,
   input wire logic [7:0]        mem_rdata_i,
   input wire logic              instr_ready_o,
   input wire logic [1:0]        phase_o,
   input wire logic              pc_load_o,
   input wire logic [PC_W-1:0]   pc_target_o,
   input wire logic              flush_o,
   input wire logic              nop_cycle_o,
   input wire logic [ADDR_W-1:0] mem_addr_o,
   input wire logic              mem_rd_o,
   input wire logic              mem_wr_o,
   input wire logic [7:0]        mem_wdata_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   function automatic logic [13:0] ea(logic [15:0] w, logic [5:0] b, logic e, logic [13:0] x);
      if (w[8])
         return {b, w[7:0]};
      if (w[7:0] > 8'h5f)
         return {6'h3f, w[7:0]};
      return e ? x + {6'h00, w[7:0]} : {6'h00, w[7:0]};
   endfunction
   sequence s_take(c);
      instr_ready_o && instr_valid_i && clk_en_i && c;
   endsequence
   sequence s_run2;
      clk_en_i ##1 clk_en_i;
   endsequence
   a_load_in_q4: assert property (pc_load_o |-> phase_o == 2'b10 && flush_o)
      else $error("pc load outside Q4 or without flush");
   a_nop_after_load: assert property (pc_load_o && clk_en_i |=> nop_cycle_o && phase_o == 2'b00)
      else $error("no idle cycle after taken branch");
   a_nop_length: assert property (nop_cycle_o && phase_o == 2'b10 && clk_en_i |=> !nop_cycle_o && instr_ready_o)
      else $error("idle cycle length wrong");
   a_jump_target: assert property (s_take(instr_word_i[15:11] == 5'h1a) ##1 s_run2 |=> pc_load_o && pc_target_o == $past(pc_i, 3) + {{9{$past(instr_word_i[10], 3)}}, $past(instr_word_i[10:0], 3), 1'b0})
      else $error("relative jump target wrong");
   a_near_taken: assert property (s_take(instr_word_i[15:8] == 8'he1) ##1 (clk_en_i && !zero_flag_i) ##1 clk_en_i |=> pc_load_o && pc_target_o == $past(pc_i, 3) + {{12{$past(instr_word_i[7], 3)}}, $past(instr_word_i[7:0], 3), 1'b0})
      else $error("not-zero branch target wrong");
   a_near_skip: assert property (s_take(instr_word_i[15:8] == 8'he1) ##1 (clk_en_i && zero_flag_i) ##1 clk_en_i |=> !pc_load_o ##1 !nop_cycle_o)
      else $error("untaken branch loaded pc");
   a_bit_read: assert property (s_take(instr_word_i[15:12] == 4'h8) |=> mem_rd_o && mem_addr_o == ea($past(instr_word_i), $past(bank_selector_reg_i), $past(ext_set_en_i), $past(index_base_i)))
      else $error("bit set address wrong");
   a_bit_write: assert property (s_take(instr_word_i[15:12] == 4'h8) ##1 s_run2 |=> mem_wr_o && mem_wdata_o == ($past(mem_rdata_i) | (8'h01 << $past(instr_word_i[11:9], 3))))
      else $error("bit set write wrong");
endmodule
bind bbs_exec bbs_exec_checker #(.PC_W(PC_W), .BSR_W(BSR_W), .ADDR_W(ADDR_W)) bbs_exec_checker_i (
   .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
   .instr_valid_i(instr_valid_i), .instr_word_i(instr_word_i), .pc_i(pc_i),
   .zero_flag_i(zero_flag_i), .bank_selector_reg_i(bank_selector_reg_i),
   .ext_set_en_i(ext_set_en_i), .index_base_i(index_base_i), .mem_rdata_i(mem_rdata_i),
   .instr_ready_o(instr_ready_o), .phase_o(phase_o), .pc_load_o(pc_load_o),
   .pc_target_o(pc_target_o), .flush_o(flush_o), .nop_cycle_o(nop_cycle_o),
   .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
   .mem_wdata_o(mem_wdata_o));

// file: bbs_tb.sv
// Self-checking testbench for the branch and bit-set execution unit
`timescale 1ns/10ps
module tb;
   logic        clk_sys_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic        clk_en_i  = 1'b1;
   logic [15:0] word      = 16'h0000;
   logic [20:0] pc        = 21'h000000;
   logic        zf        = 1'b0;
   logic [5:0]  bank_selector_reg       = 6'h00;
   logic        ext       = 1'b0;
   logic [7:0]  rdata     = 8'hdb;
   logic        vld       = 1'b1;
   logic        rdy, pld, fl, nop, rd, wr;
   logic [1:0]  ph;
   logic [20:0] tgt;
   logic [13:0] addr;
   logic [7:0]  wdata;
   int          bad_count = 0;
   int          checks    = 0;
   bbs_exec bbs_exec_i (
      .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
      .instr_valid_i(vld), .instr_word_i(word), .pc_i(pc), .zero_flag_i(zf),
      .bank_selector_reg_i(bank_selector_reg), .ext_set_en_i(ext), .index_base_i(14'h3ff0),
      .mem_rdata_i(rdata), .instr_ready_o(rdy), .phase_o(ph), .pc_load_o(pld),
      .pc_target_o(tgt), .flush_o(fl), .nop_cycle_o(nop), .mem_addr_o(addr),
      .mem_rd_o(rd), .mem_wr_o(wr), .mem_wdata_o(wdata));
   initial
   begin
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Present a word and return at the Q1 edge that takes it
   task automatic issue(logic [15:0] w, logic [20:0] p, logic z);
      int n;
      n = 0;
      word <= w;
      pc <= p;
      zf <= z;
      do
      begin
         @(negedge clk_sys_i);
         n++;
      end
      while (!rdy && n < 20);
      @(posedge clk_sys_i);
      word <= 16'h0000;
   endtask
   task automatic t_branch(logic far, int n, logic [20:0] p, logic z);
      logic [20:0] exp;
      logic        tk;
      int          k;
      exp = p + 21'(2 * n);
      tk = far | !z;
      k = 0;
      issue(far ? {5'h1a, 11'(n)} : {8'he1, 8'(n)}, p, z);
      repeat (2) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      chk("pc load", pld, tk);
      chk("flush", fl, tk);
      if (tk)
         chk("target", tgt, exp);
      do
      begin
         @(negedge clk_sys_i);
         k++;
         if (k == 1 || k == 4)
            chk("nop cycle", nop, tk);
      end
      while (!rdy && k < 20);
      chk("cycles", k, tk ? 5 : 1);
      @(posedge clk_sys_i);
      $display("branch test done");
   endtask
   task automatic t_bit(logic [2:0] b, logic a, logic [7:0] f, logic e, logic [13:0] ea);
      bank_selector_reg <= 6'h2b;
      ext <= e;
      issue({4'h8, b, a, f}, 21'h000100, 1'b0);
      @(negedge clk_sys_i);
      chk("read", rd, 1'b1);
      chk("addr", addr, ea);
      @(posedge clk_sys_i);
      rdata <= 8'h24;
      @(posedge clk_sys_i);
      rdata <= 8'hdb;
      @(negedge clk_sys_i);
      chk("write", wr, 1'b1);
      chk("wdata", wdata, 8'h24 | (8'h01 << b));
      chk("no load", pld, 1'b0);
      @(posedge clk_sys_i);
      $display("bit set test done");
   endtask
   task automatic t_hold;
      clk_en_i <= 1'b0;
      repeat (4) @(negedge clk_sys_i);
      chk("frozen phase", ph, 2'b01);
      @(posedge clk_sys_i);
      clk_en_i <= 1'b1;
      @(posedge clk_sys_i);
      $display("hold test done");
   endtask
   // A word offered without valid in Q1 must not be executed
   task automatic t_invalid;
      vld <= 1'b0;
      issue(16'he140, 21'h000300, 1'b0);
      vld <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      chk("invalid load", pld, 1'b0);
      @(negedge clk_sys_i);
      chk("invalid nop", nop, 1'b0);
      chk("invalid ready", rdy, 1'b1);
      @(posedge clk_sys_i);
      $display("invalid word test done");
   endtask
   task automatic t_reset;
      repeat (6) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      @(negedge clk_sys_i);
      chk("reset phase", ph, 2'b00);
      chk("reset ready", rdy, 1'b1);
      chk("reset load", pld, 1'b0);
      chk("reset nop", nop, 1'b0);
      @(posedge clk_sys_i);
      $display("reset test done");
   endtask
   initial
   begin
      t_reset;
      t_branch(1'b0, 127, 21'h000100, 1'b0);
      t_branch(1'b0, -128, 21'h000010, 1'b0);
      t_branch(1'b0, 5, 21'h000200, 1'b1);
      t_branch(1'b1, 1023, 21'h1ffffe, 1'b0);
      t_branch(1'b1, -1024, 21'h000800, 1'b1);
      t_hold;
      t_invalid;
      t_bit(3'd7, 1'b1, 8'h80, 1'b0, 14'h2b80);
      t_bit(3'd0, 1'b0, 8'h5f, 1'b1, 14'h004f);
      t_bit(3'd3, 1'b0, 8'h60, 1'b1, 14'h3f60);
      t_bit(3'd5, 1'b0, 8'h10, 1'b0, 14'h0010);
      t_bit(3'd1, 1'b1, 8'h10, 1'b1, 14'h2b10);
      test_done;
   end
   initial
   begin
      repeat (3000) @(posedge clk_sys_i);
      bad_count++;
      test_done;
   end
endmodule
